// ===== design/lpm_ctrl.sv
// lpm_ctrl: run, debug halt, wait and stop sequencing with pin latch control
// assumes aresetn is the deep-stop power-on style reset; wake pins come from outside
`timescale 1ns/1ps
module lpm_ctrl (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        debug_mode_select_pin,
  input  wire logic        wait_exec,
  input  wire logic        stop_exec,
  input  wire logic        irq_pending,
  input  wire logic        pin_reset_n,
  input  wire logic        external_interrupt_pin,
  input  wire logic [7:0]  wake_src,
  input  wire logic        rtc_wake_en,
  input  wire logic        powerdown_wake,
  input  wire logic        dbg_cmd_valid,
  input  wire logic [2:0]  dbg_cmd,
  output logic             dbg_cmd_exec,
  output logic             dbg_mem_access,
  output logic [1:0]       dbg_resp,
  output logic             cpu_run,
  output logic             cpu_clk_en,
  output logic             bus_clk_en,
  output logic             debug_clk_en,
  output logic             regulator_full,
  output logic             clear_int_mask,
  output logic             take_irq_vector,
  output logic             illegal_op_reset,
  output logic             deep_power_off,
  output logic             pin_latch_hold,
  output logic             low_trip_reset_en
);
  lpm_pkg::lpm_state_t state_ff, nxt_state;
  logic [4:0] ctrl_ff;
  logic       ack_ff, recov_ff, latch_ff, strap_ff, stop_regfull_ff, stop_dbg_ff;
  logic [2:0] rst_pin_s, irqp_s, rtc_s;
  logic [7:0] wake_s1, wake_s2, wake_s3;
  logic       aw_ff, w_ff, bvalid_ff, rvalid_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [1:0]  bresp_ff, rresp_ff;
  logic        dbg_exec_ff, mem_acc_ff;
  logic [1:0]  dbg_resp_ff;
  logic        out_ill_ff, out_irqv_ff, out_clrmask_ff;

  // synchronisers: second and third stage agree before use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_pin_s <= 3'h7;
      irqp_s    <= 3'h7;
      rtc_s     <= 3'h0;
      wake_s1   <= 8'h00;
      wake_s2   <= 8'h00;
      wake_s3   <= 8'h00;
    end else begin
      rst_pin_s <= {rst_pin_s[1:0], pin_reset_n};
      irqp_s    <= {irqp_s[1:0], external_interrupt_pin};
      rtc_s     <= {rtc_s[1:0], wake_src[lpm_pkg::wake_rtc]};
      wake_s1   <= wake_src;
      wake_s2   <= wake_s1;
      wake_s3   <= wake_s2;
    end
  end

  wire       pin_rst_evt = !rst_pin_s[1] && !rst_pin_s[2];
  wire       irq_low     = !irqp_s[1] && !irqp_s[2];
  wire       rtc_evt     = rtc_s[1] && rtc_s[2] && rtc_wake_en;
  wire [7:0] wake_ok     = wake_s2 & wake_s3;
  wire       shallow_wake = |wake_ok;

  // stop mode selection
  wire stop_en   = ctrl_ff[lpm_pkg::stop_enable_pos];
  wire dbg_en    = ctrl_ff[lpm_pkg::debug_enable_pos];
  wire volt_stop = ctrl_ff[lpm_pkg::volt_detect_pos] && ctrl_ff[lpm_pkg::volt_detect_stop_pos];
  wire pd_sel    = ctrl_ff[lpm_pkg::partial_pd_pos];
  wire pick_deep = !dbg_en && !volt_stop && pd_sel;

  wire is_halt  = state_ff == lpm_pkg::st_halt;
  wire is_run   = state_ff == lpm_pkg::st_run;
  wire is_wait  = state_ff == lpm_pkg::st_wait;
  wire is_stop  = state_ff == lpm_pkg::st_shallow || state_ff == lpm_pkg::st_deep;

  // debug command classification
  wire cmd_nonintr = dbg_cmd == lpm_pkg::cmd_mem || dbg_cmd == lpm_pkg::cmd_mem_status ||
                     dbg_cmd == lpm_pkg::cmd_dbg_reg || dbg_cmd == lpm_pkg::cmd_halt;
  wire cmd_active  = dbg_cmd == lpm_pkg::cmd_cpu_reg || dbg_cmd == lpm_pkg::cmd_step ||
                     dbg_cmd == lpm_pkg::cmd_resume;
  wire dbg_link    = is_run || is_halt || is_wait || (state_ff == lpm_pkg::st_shallow && stop_dbg_ff);
  wire low_pw_st   = is_wait || is_stop;
  wire cmd_ok      = dbg_cmd_valid && dbg_link &&
                     ((!low_pw_st && cmd_nonintr) || (is_halt && cmd_active) ||
                      (low_pw_st && dbg_cmd == lpm_pkg::cmd_halt));
  wire status_err  = dbg_cmd_valid && dbg_link && low_pw_st &&
                     dbg_cmd == lpm_pkg::cmd_mem_status;
  wire halt_req    = cmd_ok && dbg_cmd == lpm_pkg::cmd_halt;
  wire resume_req  = cmd_ok && dbg_cmd == lpm_pkg::cmd_resume;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      lpm_pkg::st_run: begin
        if (halt_req) begin
          nxt_state = lpm_pkg::st_halt;
        end else if (wait_exec) begin
          nxt_state = lpm_pkg::st_wait;
        end else if (stop_exec && stop_en) begin
          nxt_state = pick_deep ? lpm_pkg::st_deep : lpm_pkg::st_shallow;
        end
      end
      lpm_pkg::st_halt: begin
        if (resume_req) begin
          nxt_state = lpm_pkg::st_run;
        end
      end
      lpm_pkg::st_wait: begin
        if (halt_req) begin
          nxt_state = lpm_pkg::st_halt;
        end else if (irq_pending) begin
          nxt_state = lpm_pkg::st_run;
        end
      end
      lpm_pkg::st_shallow: begin
        if (halt_req && stop_dbg_ff) begin
          nxt_state = lpm_pkg::st_halt;
        end else if (shallow_wake) begin
          nxt_state = lpm_pkg::st_run;
        end
      end
      lpm_pkg::st_deep: begin
        nxt_state = lpm_pkg::st_deep;  // left through deep_wake or aresetn
      end
    endcase
  end

  wire deep_entry = is_run && stop_exec && stop_en && pick_deep;
  wire deep_wake  = state_ff == lpm_pkg::st_deep && (pin_rst_evt || irq_low || rtc_evt);
  wire ill_stop   = is_run && !halt_req && !wait_exec && stop_exec && !stop_en;

  // axi4-lite handshakes
  wire aw_take = s_axi_awvalid && !aw_ff && !bvalid_ff;
  wire w_take  = s_axi_wvalid && !w_ff && !bvalid_ff;
  wire wr_go   = aw_ff && w_ff && !bvalid_ff;
  wire ar_take = s_axi_arvalid && !rvalid_ff;
  wire wr_ctrl = wr_go && awaddr_ff == lpm_pkg::ctrl_addr;
  wire wr_ack  = wr_go && awaddr_ff == lpm_pkg::ack_addr && wdata_ff[lpm_pkg::ack_pos];
  wire wr_hit  = awaddr_ff == lpm_pkg::ctrl_addr || awaddr_ff == lpm_pkg::ack_addr;
  wire rd_hit  = s_axi_araddr == lpm_pkg::ctrl_addr || s_axi_araddr == lpm_pkg::status_addr ||
                 s_axi_araddr == lpm_pkg::ack_addr;
  wire [31:0] status_word = {24'h000000, low_trip_reset_en, latch_ff, recov_ff,
                             strap_ff, 1'b0, state_ff};
  wire [31:0] rd_word = s_axi_araddr == lpm_pkg::ctrl_addr   ? {27'h0000000, ctrl_ff} :
                        s_axi_araddr == lpm_pkg::status_addr ? status_word : 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff     <= 1'b0;
      w_ff      <= 1'b0;
      bvalid_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff  <= 32'h00000000;
      rdata_ff  <= 32'h00000000;
      bresp_ff  <= 2'h0;
      rresp_ff  <= 2'h0;
    end else begin
      if (aw_take) begin
        aw_ff     <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        w_ff     <= 1'b1;
        wdata_ff <= s_axi_wstrb[0] ? s_axi_wdata : 32'h00000000;
      end
      if (wr_go) begin
        aw_ff     <= 1'b0;
        w_ff      <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_hit ? lpm_pkg::axi_okay : lpm_pkg::axi_slverr;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
      if (ar_take) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= rd_word;
        rresp_ff  <= rd_hit ? lpm_pkg::axi_okay : lpm_pkg::axi_slverr;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // control state, strap capture and deep-stop recovery
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff        <= lpm_pkg::st_halt;
      ctrl_ff         <= lpm_pkg::ctrl_reset;
      strap_ff        <= 1'b0;
      ack_ff          <= 1'b0;
      recov_ff        <= 1'b0;
      latch_ff        <= 1'b0;
      stop_regfull_ff <= 1'b0;
      stop_dbg_ff     <= 1'b0;
    end else begin
      if (!strap_ff) begin
        strap_ff <= 1'b1;
        state_ff <= debug_mode_select_pin ? lpm_pkg::st_run : lpm_pkg::st_halt;
      end else if (deep_wake) begin
        strap_ff <= 1'b0;
        state_ff <= lpm_pkg::st_halt;
      end else if (pin_rst_evt && is_stop) begin
        state_ff <= lpm_pkg::st_run;
      end else begin
        state_ff <= nxt_state;
      end
      if (deep_wake) begin
        ctrl_ff <= lpm_pkg::ctrl_reset;
      end else if (wr_ctrl) begin
        ctrl_ff <= wdata_ff[4:0];
      end
      if (!ack_ff && strap_ff) begin
        ack_ff   <= 1'b1;
        recov_ff <= powerdown_wake;
        latch_ff <= powerdown_wake;
      end else if (deep_wake) begin
        recov_ff <= 1'b1;
        latch_ff <= 1'b1;
      end else if (deep_entry) begin
        latch_ff <= 1'b1;
      end else if (wr_ack) begin
        recov_ff <= 1'b0;
        latch_ff <= 1'b0;
      end
      if (is_run && stop_exec && stop_en) begin
        stop_regfull_ff <= dbg_en || volt_stop;
        stop_dbg_ff     <= dbg_en;
      end
    end
  end

  // pulse outputs and debug response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dbg_exec_ff    <= 1'b0;
      mem_acc_ff     <= 1'b0;
      dbg_resp_ff    <= lpm_pkg::resp_ok;
      out_ill_ff     <= 1'b0;
      out_irqv_ff    <= 1'b0;
      out_clrmask_ff <= 1'b0;
    end else begin
      dbg_exec_ff    <= cmd_ok;
      mem_acc_ff     <= cmd_ok && (dbg_cmd == lpm_pkg::cmd_mem ||
                        dbg_cmd == lpm_pkg::cmd_mem_status);
      dbg_resp_ff    <= status_err ? lpm_pkg::resp_stopwait :
                        (dbg_cmd_valid && !cmd_ok) ? lpm_pkg::resp_refused : lpm_pkg::resp_ok;
      out_ill_ff     <= ill_stop;
      out_irqv_ff    <= (is_wait && !halt_req && irq_pending) ||
                        (state_ff == lpm_pkg::st_shallow && !(halt_req && stop_dbg_ff) &&
                         shallow_wake && !pin_rst_evt);
      out_clrmask_ff <= is_run && wait_exec && !halt_req;
    end
  end

  assign s_axi_awready     = aw_take;
  assign s_axi_wready      = w_take;
  assign s_axi_bvalid      = bvalid_ff;
  assign s_axi_bresp       = bresp_ff;
  assign s_axi_arready     = ar_take;
  assign s_axi_rvalid      = rvalid_ff;
  assign s_axi_rdata       = rdata_ff;
  assign s_axi_rresp       = rresp_ff;
  assign dbg_cmd_exec      = dbg_exec_ff;
  assign dbg_mem_access    = mem_acc_ff;
  assign dbg_resp          = dbg_resp_ff;
  assign cpu_run           = is_run;
  assign cpu_clk_en        = is_run || is_halt;
  assign bus_clk_en        = !is_stop;
  assign debug_clk_en      = !is_stop || stop_dbg_ff;
  assign regulator_full    = !is_stop || stop_regfull_ff;
  assign clear_int_mask    = out_clrmask_ff;
  assign take_irq_vector   = out_irqv_ff;
  assign illegal_op_reset  = out_ill_ff;
  assign deep_power_off    = state_ff == lpm_pkg::st_deep;
  assign pin_latch_hold    = latch_ff;
  assign low_trip_reset_en = recov_ff;

endmodule // lpm_ctrl

// ===== common/lpm_pkg.sv
// lpm_pkg: register map, field positions and encodings of the low-power mode controller
// assumes a 32-bit axi4-lite slave with word-aligned registers
// Summary of operation
// - mode-select pin low at reset gives debug halt
// - debug halt suspends cpu, waits debug commands
// - non-intrusive debug commands accepted in run and halt
// - cpu-register, step, resume commands only in halt
// - wait stops cpu clock and clears interrupt mask
// - any interrupt restarts cpu from wait
// - during wait only halt and status-access commands
// - status-access in wait or stop returns error
// - halt request wakes wait into debug halt
// - stop with stop disabled raises illegal-opcode reset
// - stop mode chosen by debug, detector, powerdown priority
// - every stop halts bus and cpu clocks
// - shallow stop retains all state
// - shallow stop left on reset or listed interrupts
// - pin reset fetches reset vector, interrupt its vector
// - detector enabled for stop keeps regulator, shallow stop
// - debug enabled keeps debug clocks, forces shallow stop
// - halt request wakes stop into debug halt
// - deep stop latches pins, powers down logic
// - deep stop left on reset, low wake pin, rtc
// - deep stop wake acts as power-on reset
// - recovery flag and latches hold until acknowledge
// - acknowledge opens pin latches
package lpm_pkg;
  localparam logic [7:0] ctrl_addr    = 8'h00;
  localparam logic [7:0] status_addr  = 8'h04;
  localparam logic [7:0] ack_addr     = 8'h08;
  // control bit positions
  localparam int stop_enable_pos      = 0;
  localparam int debug_enable_pos     = 1;
  localparam int volt_detect_pos      = 2;
  localparam int volt_detect_stop_pos = 3;
  localparam int partial_pd_pos       = 4;
  localparam logic [4:0] ctrl_reset   = 5'h00;
  localparam int ack_pos              = 0;
  // wake sources of shallow stop
  localparam int wake_rtc   = 0;
  localparam int wake_usb   = 1;
  localparam int wake_low_volt   = 2;
  localparam int wake_adc        = 3;
  localparam int wake_irq        = 4;
  localparam int wake_keyboard   = 5;
  localparam int wake_serial     = 6;
  localparam int wake_comparator = 7;
  localparam int wake_width = 8;
  // debug command classes
  localparam logic [2:0] cmd_mem        = 3'h0;
  localparam logic [2:0] cmd_mem_status = 3'h1;
  localparam logic [2:0] cmd_dbg_reg    = 3'h2;
  localparam logic [2:0] cmd_halt       = 3'h3;
  localparam logic [2:0] cmd_cpu_reg    = 3'h4;
  localparam logic [2:0] cmd_step       = 3'h5;
  localparam logic [2:0] cmd_resume     = 3'h6;
  localparam logic [1:0] resp_ok        = 2'h0;
  localparam logic [1:0] resp_refused   = 2'h1;
  localparam logic [1:0] resp_stopwait  = 2'h2;
  localparam logic [1:0] axi_okay       = 2'h0;
  localparam logic [1:0] axi_slverr     = 2'h2;
  typedef enum logic [2:0] {
    st_run, st_halt, st_wait, st_shallow, st_deep
  } lpm_state_t;
endpackage

// ===== tb/lpm_host_model.sv
// lpm_host_model: debug host and external pin side of the mode controller
// assumes the bench calls send just after a rising clock edge
`timescale 1ns/1ps
module lpm_host_model (
  input  wire logic       aclk,
  output logic            dbg_cmd_valid,
  output logic [2:0]      dbg_cmd,
  output logic            external_interrupt_pin
);
  initial begin
    dbg_cmd_valid = 1'b0;
    dbg_cmd = 3'h7;
    external_interrupt_pin = 1'b1;
  end
  // one-cycle command, class line scrambled once released
  task automatic send(input logic [2:0] c);
    @(posedge aclk);
    dbg_cmd_valid <= 1'b1;
    dbg_cmd <= c;
    @(posedge aclk);
    dbg_cmd_valid <= 1'b0;
    dbg_cmd <= ~c;
  endtask
  // wake pin held low past the synchroniser, then back high
  task automatic pin_wake();
    @(posedge aclk);
    external_interrupt_pin <= 1'b0;
    repeat (6) @(posedge aclk);
    external_interrupt_pin <= 1'b1;
  endtask
endmodule // lpm_host_model

// ===== tb/lpm_ctrl_monitor.sv
// lpm_ctrl_monitor: port-level checks of the mode controller
// assumes binding onto lpm_ctrl, single clock domain
`timescale 1ns/1ps
module lpm_ctrl_monitor (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_wvalid,
  input wire logic       wait_exec,
  input wire logic       stop_exec,
  input wire logic       dbg_cmd_valid,
  input wire logic [2:0] dbg_cmd,
  input wire logic       dbg_cmd_exec,
  input wire logic       cpu_run,
  input wire logic       cpu_clk_en,
  input wire logic       bus_clk_en,
  input wire logic       debug_clk_en,
  input wire logic       regulator_full,
  input wire logic       clear_int_mask,
  input wire logic       illegal_op_reset,
  input wire logic       deep_power_off,
  input wire logic       pin_latch_hold
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  exec_cause_a: assert property (dbg_cmd_exec |-> $past(dbg_cmd_valid))
    else $error("exec without command");
  run_accept_a: assert property (dbg_cmd_valid && cpu_run && dbg_cmd <= lpm_pkg::cmd_halt
    |=> dbg_cmd_exec) else $error("run command not taken");
  run_refuse_a: assert property (dbg_cmd_valid && cpu_run && dbg_cmd >= lpm_pkg::cmd_cpu_reg
    |=> !dbg_cmd_exec) else $error("halt-only command taken in run");
  wait_mask_a: assert property (wait_exec && cpu_run |-> ##[1:2] clear_int_mask)
    else $error("mask not cleared on wait");
  wait_clk_a: assert property (wait_exec && cpu_run |-> ##[1:2] !cpu_clk_en)
    else $error("cpu clock runs in wait");
  stop_clks_a: assert property (!bus_clk_en |-> !cpu_clk_en)
    else $error("cpu clock runs in stop");
  illegal_src_a: assert property (illegal_op_reset |-> $past(stop_exec) || $past(stop_exec, 2))
    else $error("illegal reset without stop");
  dbg_stop_a: assert property (!bus_clk_en && debug_clk_en
    |-> regulator_full && !deep_power_off) else $error("debug stop not shallow");
  deep_latch_a: assert property (deep_power_off |-> ##[0:1] pin_latch_hold)
    else $error("pins not latched in deep stop");
  latch_ack_a: assert property ($fell(pin_latch_hold)
    |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2)) else $error("latch opened without write");
endmodule // lpm_ctrl_monitor
bind lpm_ctrl lpm_ctrl_monitor lpm_ctrl_monitor_inst (.aclk, .aresetn, .s_axi_wvalid,
  .wait_exec, .stop_exec, .dbg_cmd_valid, .dbg_cmd, .dbg_cmd_exec, .cpu_run, .cpu_clk_en,
  .bus_clk_en, .debug_clk_en, .regulator_full, .clear_int_mask, .illegal_op_reset,
  .deep_power_off, .pin_latch_hold);

// ===== tb/lpm_ctrl_tb.sv
// lpm_ctrl_tb: self-checking bench for the low-power mode controller
// assumes lpm_ctrl, lpm_host_model and the bound monitor are compiled first
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin err_total++; \
  $display("BAD %s exp %h got %h", n, e, a); end end
module lpm_ctrl_tb;
  logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, debug_mode_select_pin = 0, wait_exec = 0;
  logic        stop_exec = 0, irq_pending = 0, pin_reset_n = 1, rtc_wake_en = 0;
  logic        powerdown_wake = 0, dbg_cmd_valid, external_interrupt_pin, dbg_cmd_exec;
  logic        dbg_mem_access, cpu_run, cpu_clk_en, bus_clk_en, debug_clk_en, regulator_full;
  logic        clear_int_mask, take_irq_vector, illegal_op_reset, deep_power_off;
  logic        pin_latch_hold, low_trip_reset_en, e, seen;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, wake_src = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, seed = 32'haac8a784;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [2:0]  dbg_cmd, m;
  logic [1:0]  s_axi_bresp, s_axi_rresp, dbg_resp, r;
  logic [4:0]  c;
  logic [4:0]  cor [4] = '{5'h11, 5'h1d, 5'h13, 5'h19};
  int          err_total = 0, checked = 0, cyc = 0;
  always #2 aclk = ~aclk;
  lpm_ctrl lpm_ctrl_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .debug_mode_select_pin, .wait_exec, .stop_exec, .irq_pending,
    .pin_reset_n, .external_interrupt_pin, .wake_src, .rtc_wake_en, .powerdown_wake,
    .dbg_cmd_valid, .dbg_cmd, .dbg_cmd_exec, .dbg_mem_access, .dbg_resp, .cpu_run, .cpu_clk_en,
    .bus_clk_en, .debug_clk_en, .regulator_full, .clear_int_mask, .take_irq_vector,
    .illegal_op_reset, .deep_power_off, .pin_latch_hold, .low_trip_reset_en);
  lpm_host_model lpm_host_model_inst (.aclk, .dbg_cmd_valid, .dbg_cmd, .external_interrupt_pin);
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [2:0] exp_mode(input logic [4:0] k);
    if (k[1] || (k[2] && k[3]) || !k[4]) return lpm_pkg::st_shallow;
    return lpm_pkg::st_deep;
  endfunction
  task automatic final_report;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w;
    aw = 1;
    w = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready === 1'b1) aw = 0;
      if (w && s_axi_wready === 1'b1) w = 0;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    s_axi_bready <= 1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    s_axi_rready <= 1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic dbg(input logic [2:0] k);
    lpm_host_model_inst.send(k);
    #1;
    e = dbg_cmd_exec;
    r = dbg_resp;
  endtask
  task automatic pulse(input bit stp);
    @(posedge aclk);
    if (stp) stop_exec <= 1;
    else wait_exec <= 1;
    @(posedge aclk);
    stop_exec <= 0;
    wait_exec <= 0;
  endtask
  task automatic expect_state(input logic [2:0] s);
    int n;
    n = 0;
    do begin
      rd(lpm_pkg::status_addr);
      n++;
    end while (d[2:0] !== s && n < 30);
    `CHK("state", s, d[2:0])
  endtask
  task automatic do_reset(input logic strap, input logic pdw);
    aresetn <= 0;
    debug_mode_select_pin <= strap;
    powerdown_wake <= pdw;
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
  endtask
  initial begin
    do_reset(0, 0);
    expect_state(lpm_pkg::st_halt);
    rd(lpm_pkg::ctrl_addr);
    `CHK("ctrl", 32'h0, d)
    rd(8'h0c);
    `CHK("rresp", lpm_pkg::axi_slverr, r)
    dbg(lpm_pkg::cmd_cpu_reg);
    `CHK("exec", 1'b1, e)
    dbg(lpm_pkg::cmd_resume);
    expect_state(lpm_pkg::st_run);
    for (int i = 0; i < 7; i++) begin
      if (i == 3) continue;
      dbg(i[2:0]);
      `CHK("resp", (i > 3) ? lpm_pkg::resp_refused : lpm_pkg::resp_ok, r)
    end
    pulse(0);
    expect_state(lpm_pkg::st_wait);
    dbg(lpm_pkg::cmd_mem_status);
    `CHK("resp", lpm_pkg::resp_stopwait, r)
    `CHK("mem", 1'b0, dbg_mem_access)
    dbg(lpm_pkg::cmd_mem);
    `CHK("exec", 1'b0, e)
    seen = 0;
    irq_pending <= 1;
    repeat (4) @(posedge aclk) seen |= take_irq_vector;
    `CHK("irq_vec", 1'b1, seen)
    expect_state(lpm_pkg::st_run);
    irq_pending <= 0;
    pulse(0);
    dbg(lpm_pkg::cmd_halt);
    expect_state(lpm_pkg::st_halt);
    dbg(lpm_pkg::cmd_resume);
    seen = 0;
    pulse(1);
    repeat (4) @(posedge aclk) seen |= illegal_op_reset;
    `CHK("illegal", 1'b1, seen)
    do_reset(1, 0);
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      c = (i < 4) ? cor[i] : (seed[4:0] | 5'h01);
      m = exp_mode(c);
      wr(lpm_pkg::ctrl_addr, {27'h0, c});
      pulse(1);
      expect_state(m);
      rd(lpm_pkg::ctrl_addr);
      `CHK("ctrl", 32'(c), d)
      `CHK("bus_clk", 1'b0, bus_clk_en)
      if (c[1]) begin
        `CHK("dbg_clk", 1'b1, debug_clk_en)
        dbg(lpm_pkg::cmd_mem_status);
        `CHK("resp", lpm_pkg::resp_stopwait, r)
        `CHK("mem", 1'b0, dbg_mem_access)
        dbg(lpm_pkg::cmd_halt);
        expect_state(lpm_pkg::st_halt);
        dbg(lpm_pkg::cmd_step);
        `CHK("exec", 1'b1, e)
        dbg(lpm_pkg::cmd_resume);
      end else if (m == lpm_pkg::st_shallow) begin
        dbg(lpm_pkg::cmd_mem_status);
        `CHK("resp", lpm_pkg::resp_refused, r)
        seen = 0;
        if (i == 1) pin_reset_n <= 0;
        else wake_src <= 8'h01 << seed[10:8];
        repeat (8) @(posedge aclk) seen |= take_irq_vector;
        `CHK("irq_vec", i != 1, seen)
        expect_state(lpm_pkg::st_run);
        wake_src <= 0;
        pin_reset_n <= 1;
      end else begin
        `CHK("latch", 1'b1, pin_latch_hold)
        if (i == 0) lpm_host_model_inst.pin_wake();
        else do_reset(1, 1);
        expect_state(lpm_pkg::st_run);
        rd(lpm_pkg::ctrl_addr);
        `CHK("ctrl", 32'h0, d)
        `CHK("low_trip", 1'b1, low_trip_reset_en)
        rd(lpm_pkg::status_addr);
        `CHK("recov", 2'h3, d[6:5])
        wr(lpm_pkg::ack_addr, seed | 32'h1);
        rd(lpm_pkg::status_addr);
        `CHK("recov", 2'h0, d[6:5])
        `CHK("latch", 1'b0, pin_latch_hold)
      end
    end
    final_report();
  end
endmodule // lpm_ctrl_tb
